// ---- baex_map.vh ----
// Opcode fields and constants of the byte arithmetic execution unit
`ifndef BAEX_MAP_VH
`define BAEX_MAP_VH
`define BAEX_OPC_HI        15
`define BAEX_OPC_LO        9
`define BAEX_OPC_W         7
`define BAEX_DEST_BIT      8
`define BAEX_FILE_HI       7
`define BAEX_FILE_LO       0
`define BAEX_OPC_INC       7'h0A
`define BAEX_OPC_INCSZ     7'h0F
`define BAEX_OPC_NEG       7'h16
`define BAEX_OPC_MULREG    8'h34
`define BAEX_OPC_MULLIT    8'hBC
`define BAEX_NOP_WORD      16'h0000
`define BAEX_ACC_RESET     8'h00
`define BAEX_PROD_RESET    8'h00
`define BAEX_FLAG_RESET    1'b0
`endif

// ---- baex_regfile.v ----
// Data memory file of 256 bytes with registered read data
`timescale 1ns/1ps
`default_nettype none
module baex_regfile (
  // Clock
  input  wire       clk,
  // Read port
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  // Write port
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data
);
  reg [7:0] mem [0:255];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ---- baex_exec_unit.v ----
// Execution datapath for increment, skip, multiply and negate instructions
// Function
// RULE_01 - Increment adds one to a file byte, updating overflow, carry, half carry, zero.
// RULE_02 - Increment result goes to accumulator if destination bit zero, else file byte.
// RULE_03 - Increment-skip-zero leaves flags; zero result discards next instruction, two cycles; the code takes four clocks from issue to done.
// RULE_04 - Register multiply: accumulator times file byte, unsigned, into product pair.
// RULE_05 - Product high byte holds upper eight bits, low byte lower eight.
// RULE_06 - Multiply leaves accumulator and file byte unchanged.
// RULE_07 - Multiply never touches flags, even for a zero product.
// RULE_08 - Literal multiply: literal times accumulator into product pair, one cycle; the code takes three clocks from issue to done.
// RULE_09 - Negate forms inverted accumulator plus one, updating all four flags.
// RULE_10 - Negate select zero writes accumulator and file; one writes file only.
// RULE_11 - Eight opcode bits address any of 256 file bytes; one bit selects destination.
// RULE_12 - All-zero opcode is a one-cycle no-operation changing nothing; the code takes three clocks from issue to done.
`timescale 1ns/1ps
`default_nettype none
`include "baex_map.vh"
module baex_exec_unit (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Instruction issue
  input  wire        instr_valid,
  input  wire [15:0] instr_word,
  output wire        instr_ready,
  // Execution status
  output reg         done,
  output reg         skip_next,
  output wire        busy,
  // Architectural state
  output reg  [7:0]  working_accumulator,
  output reg  [7:0]  product_high_byte,
  output reg  [7:0]  product_low_byte,
  output reg         signed_wrap_flag,
  output reg         carry_flag,
  output reg         half_carry_flag,
  output reg         zero_flag,
  // Data memory write-through view
  output reg         mem_wr,
  output reg  [7:0]  mem_wr_addr,
  output reg  [7:0]  mem_wr_data
);
  // States
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_READ = 4'h2;
  localparam [3:0] ST_EXEC = 4'h4;
  localparam [3:0] ST_SKIP = 4'h8;

  // Operation decode codes
  localparam [2:0] OP_NONE   = 3'h0;
  localparam [2:0] OP_INC    = 3'h1;
  localparam [2:0] OP_INCSZ  = 3'h2;
  localparam [2:0] OP_NEG    = 3'h3;
  localparam [2:0] OP_MULREG = 3'h4;
  localparam [2:0] OP_MULLIT = 3'h5;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [15:0] op_word;
  reg  [2:0]  op_kind;
  reg  [2:0]  next_kind;

  wire [7:0]  file_rdata;
  wire [7:0]  file_addr = op_word[`BAEX_FILE_HI:`BAEX_FILE_LO]; // RULE_11
  wire        dest_bit  = op_word[`BAEX_DEST_BIT]; // RULE_11
  wire [7:0]  issue_addr = instr_word[`BAEX_FILE_HI:`BAEX_FILE_LO];
  // Issue bus may change once taken, so later reads use the held copy
  wire [7:0]  read_addr  = (state == ST_IDLE) ? issue_addr : file_addr;

  reg         wr_en;
  reg  [7:0]  wr_data;
  reg  [7:0]  next_acc;
  reg         next_wrap;
  reg         next_carry;
  reg         next_half;
  reg         next_zero;
  reg  [15:0] next_prod;
  reg         next_done;
  reg         next_skip;

  baex_regfile u_file (
    .clk     (clk),
    .rd_addr (read_addr),
    .rd_data (file_rdata),
    .wr_en   (wr_en),
    .wr_addr (file_addr),
    .wr_data (wr_data)
  );

  assign instr_ready = (state == ST_IDLE);
  assign busy        = (state != ST_IDLE);

  // Opcode decode on issue
  always @* begin
    next_kind = OP_NONE;
    if (instr_word == `BAEX_NOP_WORD) begin
      next_kind = OP_NONE; // RULE_12
    end else if (instr_word[15:8] == `BAEX_OPC_MULREG) begin
      next_kind = OP_MULREG; // RULE_04
    end else if (instr_word[15:8] == `BAEX_OPC_MULLIT) begin
      next_kind = OP_MULLIT; // RULE_08
    end else if (instr_word[`BAEX_OPC_HI:`BAEX_OPC_LO] == `BAEX_OPC_INC) begin
      next_kind = OP_INC; // RULE_01
    end else if (instr_word[`BAEX_OPC_HI:`BAEX_OPC_LO] == `BAEX_OPC_INCSZ) begin
      next_kind = OP_INCSZ; // RULE_03
    end else if (instr_word[`BAEX_OPC_HI:`BAEX_OPC_LO] == `BAEX_OPC_NEG) begin
      next_kind = OP_NEG; // RULE_09
    end
  end

  // Arithmetic
  wire [8:0]  inc_sum  = {1'b0, file_rdata} + 9'h001; // RULE_01
  wire [4:0]  inc_half = {1'b0, file_rdata[3:0]} + 5'h01;
  // Signed wrap: positive addend whose sum turns negative
  wire        inc_ovf  = (~file_rdata[7]) & inc_sum[7];
  wire [7:0]  acc_inv  = ~working_accumulator;
  wire [8:0]  neg_sum  = {1'b0, acc_inv} + 9'h001; // RULE_09
  wire [4:0]  neg_half = {1'b0, acc_inv[3:0]} + 5'h01;
  wire        neg_ovf  = (~acc_inv[7]) & neg_sum[7];
  wire [15:0] mul_reg  = working_accumulator * file_rdata; // RULE_04
  wire [15:0] mul_lit  = working_accumulator * op_word[7:0]; // RULE_08

  // Sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (instr_valid) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        if ((op_kind == OP_INCSZ) && (inc_sum[7:0] == 8'h00)) begin
          next_state = ST_SKIP; // RULE_03
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_SKIP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Memory write value
  always @* begin
    wr_en   = 1'b0;
    wr_data = 8'h00;
    if (state == ST_EXEC) begin
      case (op_kind)
        OP_INC, OP_INCSZ: begin
          wr_en   = dest_bit; // RULE_02
          wr_data = inc_sum[7:0];
        end
        OP_NEG: begin
          wr_en   = 1'b1; // RULE_10
          wr_data = neg_sum[7:0];
        end
        default: begin
          wr_en   = 1'b0; // RULE_06
          wr_data = 8'h00;
        end
      endcase
    end
  end

  // Next accumulator and flags
  always @* begin
    next_acc   = working_accumulator;
    next_wrap  = signed_wrap_flag; // RULE_07
    next_carry = carry_flag;
    next_half  = half_carry_flag;
    next_zero  = zero_flag;
    if (state == ST_EXEC) begin
      case (op_kind)
        OP_INC: begin
          if (!dest_bit) begin
            next_acc = inc_sum[7:0]; // RULE_02
          end
          next_wrap  = inc_ovf; // RULE_01
          next_carry = inc_sum[8];
          next_half  = inc_half[4];
          next_zero  = (inc_sum[7:0] == 8'h00);
        end
        OP_INCSZ: begin
          if (!dest_bit) begin
            next_acc = inc_sum[7:0]; // RULE_03
          end
        end
        OP_NEG: begin
          if (!dest_bit) begin
            next_acc = neg_sum[7:0]; // RULE_10
          end
          next_wrap  = neg_ovf; // RULE_09
          next_carry = neg_sum[8];
          next_half  = neg_half[4];
          next_zero  = (neg_sum[7:0] == 8'h00);
        end
        default: begin
          next_acc = working_accumulator; // RULE_12
        end
      endcase
    end
  end

  // Next product pair
  always @* begin
    next_prod = {product_high_byte, product_low_byte};
    if (state == ST_EXEC) begin
      case (op_kind)
        OP_MULREG: begin
          next_prod = mul_reg; // RULE_04
        end
        OP_MULLIT: begin
          next_prod = mul_lit; // RULE_08
        end
        default: begin
          next_prod = {product_high_byte, product_low_byte};
        end
      endcase
    end
  end

  // Completion pulses
  always @* begin
    next_done = 1'b0;
    next_skip = 1'b0;
    if (state == ST_SKIP) begin
      next_done = 1'b1; // RULE_03
      next_skip = 1'b1;
    end else if ((state == ST_EXEC) && (next_state == ST_IDLE)) begin
      next_done = 1'b1;
    end
  end

  // Sequencer and issue capture
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= ST_IDLE;
      op_word <= `BAEX_NOP_WORD;
      op_kind <= OP_NONE;
    end else begin
      state <= next_state;
      if ((state == ST_IDLE) && instr_valid) begin
        op_word <= instr_word;
        op_kind <= next_kind;
      end
    end
  end

  // Status pulses
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done      <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      done      <= next_done;
      skip_next <= next_skip;
    end
  end

  // Write-through view of the file
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_wr      <= 1'b0;
      mem_wr_addr <= 8'h00;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr <= wr_en;
      if (wr_en) begin
        mem_wr_addr <= file_addr;
        mem_wr_data <= wr_data;
      end
    end
  end

  // Accumulator, flags and product pair
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      working_accumulator <= `BAEX_ACC_RESET;
      product_high_byte   <= `BAEX_PROD_RESET;
      product_low_byte    <= `BAEX_PROD_RESET;
      signed_wrap_flag    <= `BAEX_FLAG_RESET;
      carry_flag          <= `BAEX_FLAG_RESET;
      half_carry_flag     <= `BAEX_FLAG_RESET;
      zero_flag           <= `BAEX_FLAG_RESET;
    end else begin
      working_accumulator <= next_acc;
      product_high_byte   <= next_prod[15:8]; // RULE_05
      product_low_byte    <= next_prod[7:0];
      signed_wrap_flag    <= next_wrap;
      carry_flag          <= next_carry;
      half_carry_flag     <= next_half;
      zero_flag           <= next_zero;
    end
  end
endmodule
`default_nettype wire

// ---- baex_exec_unit_properties.sv ----
// Checker for the byte arithmetic execution unit
`timescale 1ns/1ps
`default_nettype none
module baex_exec_unit_props (
  // Clock, reset and issue
  input wire logic        clk, arst_n, instr_valid, instr_ready, busy,
  input wire logic [15:0] instr_word,
  // Status and flags
  input wire logic        done, skip_next, signed_wrap_flag, carry_flag,
  input wire logic        half_carry_flag, zero_flag, mem_wr,
  // State and memory view
  input wire logic [7:0]  working_accumulator, product_high_byte,
  input wire logic [7:0]  product_low_byte, mem_wr_addr, mem_wr_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire       go = instr_valid & instr_ready;
  wire [6:0] op = instr_word[15:9];
  wire [3:0] flg = {signed_wrap_flag, carry_flag, half_carry_flag, zero_flag};
  property p_nop;
    go && instr_word == 16'h0000 |-> ##3 done && !mem_wr
      && $stable(working_accumulator) && $stable(flg);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");
  property p_mullit;
    logic [7:0] k;
    (go && instr_word[15:8] == 8'hBC, k = instr_word[7:0]) |-> ##3 done
      && {product_high_byte, product_low_byte} == k * working_accumulator;
  endproperty
  a_mullit: assert property (p_mullit) else $error("bad product");
  property p_neg;
    logic [15:0] w;
    logic [7:0] a;
    (go && op == 7'h16, w = instr_word, a = working_accumulator) |-> ##3
      mem_wr && mem_wr_addr == w[7:0] && mem_wr_data == 8'h00 - a
      && working_accumulator == (w[8] ? a : 8'h00 - a);
  endproperty
  a_neg: assert property (p_neg) else $error("bad negate");
  property p_inc_dest;
    logic [15:0] w;
    (go && op == 7'h0A, w = instr_word) |-> ##3
      mem_wr == w[8] && (!w[8] || mem_wr_addr == w[7:0]);
  endproperty
  a_inc_dest: assert property (p_inc_dest) else $error("bad dest");
  property p_incsz_flags;
    go && op == 7'h0F |=> $stable(flg)[*4];
  endproperty
  a_incsz_flags: assert property (p_incsz_flags) else $error("flags");
  property p_mul_flags;
    $changed({product_high_byte, product_low_byte}) |-> $stable(flg)
      && $stable(working_accumulator) && !mem_wr;
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("mul side");
  property p_skip;
    skip_next |-> done;
  endproperty
  a_skip: assert property (p_skip) else $error("skip without done");
  property p_mulreg;
    go && instr_word[15:8] == 8'h34 |-> ##3 done && !mem_wr;
  endproperty
  a_mulreg: assert property (p_mulreg) else $error("mul wrote");
  c_skip: cover property (skip_next);
  c_neg_file: cover property (go && op == 7'h16 && instr_word[8]);
  c_zero: cover property (done && zero_flag);
endmodule
bind baex_exec_unit baex_exec_unit_props u_props (.*);
`default_nettype wire

// ---- baex_mem_model.sv ----
// Shadow of the data memory file, filled by the unit's writes
`timescale 1ns/1ps
`default_nettype none
module baex_mem_model (
  input wire logic       clk,
  input wire logic       mem_wr,
  input wire logic [7:0] mem_wr_addr, mem_wr_data
);
  logic [7:0] mem [256];
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end
endmodule
`default_nettype wire

// ---- baex_exec_unit_test.sv ----
// Self-checking bench for the byte arithmetic execution unit
`timescale 1ns/1ps
`default_nettype none
module baex_exec_unit_test;
  logic        clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  wire logic   rdy, done, skip, busy, ovf, cy, hc, zf, mem_wr;
  wire logic [7:0] acc, ph, pl, wa, wd;
  int n_errors = 0, checked = 0;
  logic [15:0] ws [12] = '{16'h0000, 16'h2C10, 16'h1510, 16'h1410,
    16'hBCC4, 16'h2DFF, 16'h34FF, 16'h2C00, 16'h3400, 16'hBC00,
    16'h1FFF, 16'h1EFF};
  // Expected {acc, product, carry, zero, skip}
  logic [26:0] ex [12] = '{27'h0000000, 27'h0000006, 27'h0000000,
    27'h0100000, 27'h0100C40, 27'h0100C40, 27'h0100FE0, 27'h7F00FE0,
    27'h7F7E020, 27'h7F00000, 27'h7F00000, 27'h0000001};
  baex_exec_unit uut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(rdy), .done(done),
    .skip_next(skip), .busy(busy), .working_accumulator(acc),
    .product_high_byte(ph), .product_low_byte(pl), .signed_wrap_flag(ovf),
    .carry_flag(cy), .half_carry_flag(hc), .zero_flag(zf), .mem_wr(mem_wr),
    .mem_wr_addr(wa), .mem_wr_data(wd));
  baex_mem_model u_mem (.clk(clk), .mem_wr(mem_wr), .mem_wr_addr(wa),
    .mem_wr_data(wd));
  task automatic chk(input logic [26:0] e, input logic [26:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic conclude;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Issue one word, then wait for its completion pulse
  task automatic run(input logic [15:0] w);
    int i;
    i = 0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    do @(negedge clk); while (!done && ++i < 8);
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int r = 0; r < 12; r++) begin
      run(ws[r]);
      chk(ex[r], {acc, ph, pl, cy, zf, skip});
    end
    chk(27'h00000FE, {19'h0, u_mem.mem[8'h00]});
    chk(27'h0000001, {19'h0, u_mem.mem[8'h10]});
    chk(27'h00000FF, {19'h0, u_mem.mem[8'hFF]});
    chk(27'h00000FC, {19'h0, u_mem.mem[8'h00] - 8'h02});
    arst_n <= 1'b0;
    @(posedge clk);
    chk(27'h0000001, {acc, ph, pl, cy | zf,
      ovf | hc | busy | done | skip | mem_wr, rdy});
    arst_n <= 1'b1;
    run(16'h2C20);
    chk(27'h0000006, {acc, ph, pl, cy, zf, skip});
    chk(27'h0000001, {25'h0, ovf, hc});
    run(16'h1410);
    chk(27'h0100000, {acc, ph, pl, cy, zf, skip});
    chk(27'h0000000, {25'h0, ovf, hc});
    conclude;
  end
endmodule
`default_nettype wire
